// [design/vector_map_pkg.sv]
// Constants, types and helper functions shared by the vector address map
package vector_map_pkg;

   // ------------------------------------------------------------
   // Widths and counts
   // ------------------------------------------------------------
   localparam int ADDR_W    = 16;
   localparam int VEC_W     = 5;
   localparam int IRQ_COUNT = 25;

   // ------------------------------------------------------------
   // Table layout
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0] APP_TABLE_BASE   = 16'h0000;
   localparam logic [ADDR_W-1:0] DEFAULT_BOOT_ADDR = 16'h3C00;
   localparam logic [VEC_W-1:0]  RESET_VECTOR     = 5'h01;
   localparam logic [VEC_W-1:0]  FIRST_IRQ_VECTOR = 5'h02;
   localparam logic [VEC_W-1:0]  NO_VECTOR        = 5'h00;

   // Request line index of each source; vector number is index plus two
   localparam int EXT_IRQ_0_IDX        = 0;
   localparam int EXT_IRQ_1_IDX        = 1;
   localparam int PIN_CHANGE_IRQ_0_IDX = 2;
   localparam int PIN_CHANGE_IRQ_1_IDX = 3;
   localparam int PIN_CHANGE_IRQ_2_IDX = 4;
   localparam int WATCHDOG_IRQ_IDX     = 5;
   localparam int TIMER2_CMP_A_IDX     = 6;
   localparam int TIMER2_CMP_B_IDX     = 7;
   localparam int TIMER2_OVF_IDX       = 8;
   localparam int TIMER1_CAPT_IDX      = 9;
   localparam int TIMER1_CMP_A_IDX     = 10;
   localparam int TIMER1_CMP_B_IDX     = 11;
   localparam int TIMER1_OVF_IDX       = 12;
   localparam int TIMER0_CMP_A_IDX     = 13;
   localparam int TIMER0_CMP_B_IDX     = 14;
   localparam int TIMER0_OVF_IDX       = 15;
   localparam int SPI_DONE_IDX         = 16;
   localparam int USART_RX_IDX         = 17;
   localparam int USART_EMPTY_IDX      = 18;
   localparam int USART_TX_IDX         = 19;
   localparam int ADC_DONE_IDX         = 20;
   localparam int EEPROM_READY_IDX     = 21;
   localparam int ANALOG_CMP_IDX       = 22;
   localparam int TWO_WIRE_IDX         = 23;
   localparam int SELF_PROG_READY_IDX  = 24;

   // ------------------------------------------------------------
   // Fuse coding and timing counts
   // ------------------------------------------------------------
   localparam logic       FUSE_PROGRAMMED   = 1'b0;
   localparam logic       FUSE_UNPROGRAMMED = 1'b1;
   localparam logic [2:0] UNLOCK_CYCLES     = 3'h4;
   localparam logic [2:0] SYNC_SETTLE       = 3'h3;
   localparam logic [2:0] COUNT_ONE         = 3'h1;
   localparam logic [2:0] COUNT_ZERO        = 3'h0;

   typedef enum logic [2:0] {
      st_settle = 3'b001,
      st_idle   = 3'b010,
      st_wait   = 3'b100
   } fetch_state_type;

   // Lowest pending request index; only meaningful when any bit is set
   function automatic logic [VEC_W-1:0] lowest_pending(input logic [IRQ_COUNT-1:0] req);
      logic [VEC_W-1:0] idx;
      idx = NO_VECTOR;
      for (int i = IRQ_COUNT - 1; i >= 0; i--) begin
         if (req[i]) begin
            idx = VEC_W'(i);
         end
      end
      return idx;
   endfunction : lowest_pending

   // Each vector is two words wide, counted from vector one at the base
   function automatic logic [ADDR_W-1:0] vector_address(input logic [ADDR_W-1:0] base,
                                                        input logic [VEC_W-1:0]  num);
      return base + ADDR_W'({num - RESET_VECTOR, 1'b0});
   endfunction : vector_address

endpackage : vector_map_pkg

// [design/vector_select.sv]
// Combinational picker of the winning request and its vector address
`timescale 1ns/1ns
module vector_select (
   input  wire logic [vector_map_pkg::IRQ_COUNT-1:0] irq_request,
   input  wire logic [vector_map_pkg::ADDR_W-1:0]    table_base,
   output logic                                      irq_any,
   output logic [vector_map_pkg::VEC_W-1:0]          irq_vector,
   output logic [vector_map_pkg::ADDR_W-1:0]         irq_address
);

   logic [vector_map_pkg::VEC_W-1:0] win_index;

   // ------------------------------------------------------------
   // Priority and address
   // ------------------------------------------------------------
   // Lowest vector number wins; fixed order keeps service predictable
   always_comb begin                                        // RULE5 RULE6 RULE7 RULE8
      irq_any     = |irq_request;
      win_index   = vector_map_pkg::lowest_pending(irq_request);             // RULE16
      irq_vector  = win_index + vector_map_pkg::FIRST_IRQ_VECTOR;            // RULE3
      irq_address = vector_map_pkg::vector_address(table_base, irq_vector);  // RULE1
   end

endmodule : vector_select

// [design/vector_address_map.sv]
// Reset and interrupt vector address generator with relocatable table
//
// Function
// RULE1 - Vectors are two instruction words apart
// RULE2 - Vector one serves every reset cause
// RULE3 - External and pin change requests map 0x2..0xA
// RULE4 - Watchdog timeout is vector seven at 0xC
// RULE5 - Timer2 sources map to 0xE, 0x10, 0x12
// RULE6 - Timer1 sources map to 0x14 through 0x1A
// RULE7 - Timer0 sources map to 0x1C, 0x1E, 0x20
// RULE8 - Serial peripheral and USART map 0x22..0x28
// RULE9 - ADC, EEPROM, comparator, two-wire, self-program map 0x2A..0x32
// RULE10 - Reset fetch is zero or boot address
// RULE11 - Select bit moves interrupt table to boot
// RULE12 - Fuse value one unprogrammed, zero programmed
// RULE13 - Software unlocks, then writes select within four
// RULE14 - Unlock clears after four cycles or select write
// RULE15 - Interrupts blocked during change, enable flag untouched
// RULE16 - Lowest pending vector number served first
`timescale 1ns/1ns
module vector_address_map #(
   parameter logic [15:0] BOOT_RESET_ADDR = 16'h3C00
) (
   input  wire logic                                 ref_clk,
   input  wire logic                                 reset_n,
   input  wire logic [vector_map_pkg::IRQ_COUNT-1:0] irq_request,
   input  wire logic                                 boot_reset_select_fuse,
   input  wire logic                                 global_irq_enable,
   input  wire logic                                 core_ready,
   input  wire logic                                 vector_done,
   input  wire logic                                 instr_done,
   input  wire logic                                 ctrl_write,
   input  wire logic                                 ctrl_write_select,
   input  wire logic                                 ctrl_write_unlock,
   output logic                                      fetch_valid,
   output logic                                      fetch_is_reset,
   output logic [vector_map_pkg::ADDR_W-1:0]         fetch_address,
   output logic [vector_map_pkg::VEC_W-1:0]          fetch_vector,
   output logic                                      vector_table_select,
   output logic                                      vector_change_unlock,
   output logic                                      irq_blocked
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic                                fuse_meta;
   logic                                fuse_mid;
   logic                                fuse_late;
   logic                                fuse_state;
   logic                                next_fuse_state;
   logic [2:0]                          unlock_count;
   logic [2:0]                          next_unlock_count;
   logic                                next_select;
   logic                                next_unlock;
   logic                                follow_block;
   logic                                next_follow_block;
   logic                                next_irq_blocked;
   logic                                block_now;
   vector_map_pkg::fetch_state_type     state;
   vector_map_pkg::fetch_state_type     next_state;
   logic [2:0]                          settle_count;
   logic [2:0]                          next_settle_count;
   logic                                next_fetch_valid;
   logic                                next_fetch_is_reset;
   logic [vector_map_pkg::ADDR_W-1:0]   next_fetch_address;
   logic [vector_map_pkg::VEC_W-1:0]    next_fetch_vector;
   logic [vector_map_pkg::ADDR_W-1:0]   table_base;
   logic [vector_map_pkg::ADDR_W-1:0]   reset_address;
   logic                                irq_any;
   logic [vector_map_pkg::VEC_W-1:0]    irq_vector;
   logic [vector_map_pkg::ADDR_W-1:0]   irq_address;
   logic                                irq_grant;

   // ------------------------------------------------------------
   // Fuse synchroniser
   // ------------------------------------------------------------
   // The fuse level only counts once the last two stages agree
   always_comb begin
      next_fuse_state = fuse_state;
      if (fuse_mid == fuse_late) begin
         next_fuse_state = fuse_late;
      end
   end

   // Three-stage capture; the first stage feeds nothing but the second
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         fuse_meta  <= vector_map_pkg::FUSE_UNPROGRAMMED;
         fuse_mid   <= vector_map_pkg::FUSE_UNPROGRAMMED;
         fuse_late  <= vector_map_pkg::FUSE_UNPROGRAMMED;
         fuse_state <= vector_map_pkg::FUSE_UNPROGRAMMED;
      end else begin
         fuse_meta  <= boot_reset_select_fuse;
         fuse_mid   <= fuse_meta;
         fuse_late  <= fuse_mid;
         fuse_state <= next_fuse_state;
      end
   end

   // ------------------------------------------------------------
   // Table select with timed unlock
   // ------------------------------------------------------------
   // A select write without a live unlock is dropped, guarding the table
   always_comb begin
      next_select       = vector_table_select;
      next_unlock       = vector_change_unlock;
      next_unlock_count = unlock_count;
      next_follow_block = follow_block;
      if (follow_block && instr_done) begin
         next_follow_block = 1'b0;                                       // RULE15
      end
      if (vector_change_unlock) begin
         next_unlock_count = unlock_count - vector_map_pkg::COUNT_ONE;
         if (unlock_count == vector_map_pkg::COUNT_ONE) begin
            next_unlock = 1'b0;                                          // RULE14
         end
      end
      if (ctrl_write) begin
         if (ctrl_write_unlock) begin
            next_unlock       = 1'b1;                                    // RULE13
            next_unlock_count = vector_map_pkg::UNLOCK_CYCLES;
         end else if (vector_change_unlock) begin
            next_select       = ctrl_write_select;                       // RULE13
            next_unlock       = 1'b0;                                    // RULE14
            next_unlock_count = vector_map_pkg::COUNT_ZERO;
            next_follow_block = 1'b1;                                    // RULE15
         end
      end
      next_irq_blocked = next_unlock | next_follow_block;
   end

   // Blocking starts in the very cycle the unlock is written
   assign block_now = vector_change_unlock | follow_block
                      | (ctrl_write & ctrl_write_unlock);                // RULE15

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         vector_table_select  <= 1'b0;
         vector_change_unlock <= 1'b0;
         unlock_count         <= vector_map_pkg::COUNT_ZERO;
         follow_block         <= 1'b0;
         irq_blocked          <= 1'b0;
      end else begin
         vector_table_select  <= next_select;
         vector_change_unlock <= next_unlock;
         unlock_count         <= next_unlock_count;
         follow_block         <= next_follow_block;
         irq_blocked          <= next_irq_blocked;
      end
   end

   // ------------------------------------------------------------
   // Base addresses
   // ------------------------------------------------------------
   // Select moves the interrupt table whatever the fuse says
   assign table_base = vector_table_select ? BOOT_RESET_ADDR
                                           : vector_map_pkg::APP_TABLE_BASE;      // RULE11
   // Settled level of this very edge; the registered copy lags the reset fetch
   assign reset_address = (next_fuse_state == vector_map_pkg::FUSE_PROGRAMMED)
                          ? BOOT_RESET_ADDR : vector_map_pkg::APP_TABLE_BASE;     // RULE10 RULE12

   vector_select u_select (
      .irq_request (irq_request),
      .table_base  (table_base),
      .irq_any     (irq_any),
      .irq_vector  (irq_vector),
      .irq_address (irq_address)
   );

   // The global enable is only read here, never written
   assign irq_grant = irq_any & global_irq_enable & ~block_now & core_ready; // RULE15

   // ------------------------------------------------------------
   // Fetch sequencer
   // ------------------------------------------------------------
   // Reset fetch waits for the fuse to settle so it never sees a stale level
   always_comb begin
      next_state          = state;
      next_settle_count   = settle_count;
      next_fetch_valid    = 1'b0;
      next_fetch_is_reset = fetch_is_reset;
      next_fetch_address  = fetch_address;
      next_fetch_vector   = fetch_vector;
      unique case (state)
         vector_map_pkg::st_settle: begin
            next_settle_count = settle_count + vector_map_pkg::COUNT_ONE;
            if (settle_count == vector_map_pkg::SYNC_SETTLE) begin
               next_fetch_valid    = 1'b1;
               next_fetch_is_reset = 1'b1;
               next_fetch_address  = reset_address;                      // RULE2 RULE10
               next_fetch_vector   = vector_map_pkg::RESET_VECTOR;       // RULE2
               next_state          = vector_map_pkg::st_idle;
            end
         end
         vector_map_pkg::st_idle: begin
            if (irq_grant) begin
               next_fetch_valid    = 1'b1;
               next_fetch_is_reset = 1'b0;
               next_fetch_address  = irq_address;                        // RULE1
               next_fetch_vector   = irq_vector;                         // RULE16
               next_state          = vector_map_pkg::st_wait;
            end
         end
         vector_map_pkg::st_wait: begin
            if (vector_done) begin
               next_state = vector_map_pkg::st_idle;
            end
         end
         default: begin
            next_state = vector_map_pkg::st_settle;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state          <= vector_map_pkg::st_settle;
         settle_count   <= vector_map_pkg::COUNT_ZERO;
         fetch_valid    <= 1'b0;
         fetch_is_reset <= 1'b0;
         fetch_address  <= vector_map_pkg::APP_TABLE_BASE;
         fetch_vector   <= vector_map_pkg::NO_VECTOR;
      end else begin
         state          <= next_state;
         settle_count   <= next_settle_count;
         fetch_valid    <= next_fetch_valid;
         fetch_is_reset <= next_fetch_is_reset;
         fetch_address  <= next_fetch_address;
         fetch_vector   <= next_fetch_vector;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   sequence irq_fetch_s;
      fetch_valid && !fetch_is_reset;
   endsequence

   sequence unlock_rise_s;
      $rose(vector_change_unlock);
   endsequence

   sequence select_write_s;
      ctrl_write && !ctrl_write_unlock && vector_change_unlock;
   endsequence

   // Address tied to vector number and the base in force when granted
   vector_spacing_a: assert property (irq_fetch_s |-> fetch_address ==      // RULE1
      vector_map_pkg::vector_address($past(table_base), fetch_vector))
      else $error("vector address not two words per vector");

   reset_address_a: assert property (fetch_valid && fetch_is_reset |->      // RULE2
      fetch_vector == vector_map_pkg::RESET_VECTOR && fetch_address ==
      ((fuse_state == vector_map_pkg::FUSE_PROGRAMMED) ? BOOT_RESET_ADDR
                                                       : 16'h0000))
      else $error("reset fetch address wrong");

   watchdog_slot_a: assert property (irq_fetch_s and                        // RULE4
      (fetch_vector == 5'h07) and !$past(vector_table_select) |->
      fetch_address == 16'h000C)
      else $error("watchdog vector not at 0x000C");

   first_slot_a: assert property (irq_fetch_s and                           // RULE3
      ($past(irq_request[vector_map_pkg::EXT_IRQ_0_IDX])) and
      !$past(vector_table_select) |-> fetch_address == 16'h0002)
      else $error("external request 0 not at 0x0002");

   last_slot_a: assert property (irq_fetch_s and                            // RULE9
      ($past(irq_request) == 25'h1000000) and $past(vector_table_select)
      |-> fetch_address == BOOT_RESET_ADDR + 16'h0032)
      else $error("self-program vector not at boot plus 0x0032");

   unlock_clear_a: assert property (unlock_rise_s |->                       // RULE14
      ##[1:4] !vector_change_unlock)
      else $error("unlock not cleared within four cycles");

   unlock_block_a: assert property (unlock_rise_s |->                       // RULE15
      !(fetch_valid && !fetch_is_reset) [*4])
      else $error("interrupt fetched while unlock live");

   lowest_first_a: assert property (irq_fetch_s |-> fetch_vector ==         // RULE16
      vector_map_pkg::lowest_pending($past(irq_request))
      + vector_map_pkg::FIRST_IRQ_VECTOR)
      else $error("lower vector number not served first");

   select_guard_a: assert property (!$past(vector_change_unlock) |->        // RULE11
      $stable(vector_table_select))
      else $error("table select changed without unlock");

   // A select write through a live unlock lands and starts the long block
   unlock_table_a: assert property (select_write_s |=>                      // RULE11
      vector_table_select == $past(ctrl_write_select))
      else $error("select write through unlock not applied");

   select_block_a: assert property (select_write_s |=> irq_blocked)         // RULE15
      else $error("interrupts not blocked after select write");

   reset_table_a: assert property (fetch_valid && fetch_is_reset |->        // RULE11
      !vector_table_select)
      else $error("table select not cleared by reset");

endmodule : vector_address_map

// [sim/core_model.sv]
// Behavioural processor core that takes vectors and reports when serviced
`timescale 1ns/1ns
module core_model (
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   input  wire logic       fetch_valid,
   input  wire logic       fetch_is_reset,
   input  wire logic [3:0] service_cycles,
   output logic            core_ready,
   output logic            vector_done
);
   logic       busy;
   logic [3:0] count;

   // ------------------------------------------------------------
   // Service sequence
   // ------------------------------------------------------------
   // Falling edge moves keep every level settled at the design's edge
   always @(negedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         busy        <= 1'b0;
         count       <= 4'h0;
         core_ready  <= 1'b0;
         vector_done <= 1'b0;
      end else begin
         vector_done <= 1'b0;
         // The reset fetch is not an interrupt, so it needs no done pulse
         if (fetch_valid && !fetch_is_reset) begin
            busy       <= 1'b1;
            count      <= service_cycles;
            core_ready <= 1'b0;
         end else if (busy && count != 4'h0) begin
            count <= count - 4'h1;
         end else if (busy) begin
            busy        <= 1'b0;
            vector_done <= 1'b1;
            core_ready  <= 1'b1;
         end else begin
            core_ready <= 1'b1;
         end
      end
   end
endmodule : core_model

// [sim/test_vector_address_map.sv]
// Self-checking bench for the reset and interrupt vector address map
`timescale 1ns/1ns
module test_vector_address_map;
   // Off the default so the relocation really follows the parameter
   localparam logic [15:0] BOOT_ADDR = 16'h7000;
   typedef struct {
      logic [vector_map_pkg::IRQ_COUNT-1:0] req;
      logic [4:0]                           vec;
      logic [15:0]                          addr;
   } row_type;

   logic                                 ref_clk = 1'b0;
   logic                                 reset_n = 1'b0;
   logic [vector_map_pkg::IRQ_COUNT-1:0] irq_request = '0;
   logic                                 boot_reset_select_fuse = 1'b1;
   logic                                 global_irq_enable = 1'b1;
   logic                                 instr_done = 1'b0;
   logic                                 ctrl_write = 1'b0;
   logic                                 ctrl_write_select = 1'b0;
   logic                                 ctrl_write_unlock = 1'b0;
   logic [3:0]                           service_cycles = 4'h0;
   logic                                 core_ready;
   logic                                 vector_done;
   logic                                 fetch_valid;
   logic                                 fetch_is_reset;
   logic [15:0]                          fetch_address;
   logic [4:0]                           fetch_vector;
   logic                                 vector_table_select;
   logic                                 vector_change_unlock;
   logic                                 irq_blocked;
   int                                   bad_count = 0;
   int                                   checks_done = 0;
   int                                   fetch_seen = 0;
   row_type                              rows [27];

   vector_address_map #(.BOOT_RESET_ADDR(BOOT_ADDR)) dut (
      .ref_clk(ref_clk), .reset_n(reset_n), .irq_request(irq_request),
      .boot_reset_select_fuse(boot_reset_select_fuse), .global_irq_enable(global_irq_enable),
      .core_ready(core_ready), .vector_done(vector_done), .instr_done(instr_done),
      .ctrl_write(ctrl_write), .ctrl_write_select(ctrl_write_select),
      .ctrl_write_unlock(ctrl_write_unlock), .fetch_valid(fetch_valid),
      .fetch_is_reset(fetch_is_reset), .fetch_address(fetch_address),
      .fetch_vector(fetch_vector), .vector_table_select(vector_table_select),
      .vector_change_unlock(vector_change_unlock), .irq_blocked(irq_blocked));

   core_model core (
      .ref_clk(ref_clk), .reset_n(reset_n), .fetch_valid(fetch_valid),
      .fetch_is_reset(fetch_is_reset), .service_cycles(service_cycles),
      .core_ready(core_ready), .vector_done(vector_done));

   // ------------------------------------------------------------
   // Clock, fetch counter and watchdog
   // ------------------------------------------------------------
   // 50 ns period
   initial begin
      forever #25 ref_clk = ~ref_clk;
   end

   // Counted at the edge that ends each pulse; tasks read it on falling edges, so no race
   always @(posedge ref_clk) begin
      if (fetch_valid === 1'b1) fetch_seen++;
   end

   // The whole sequence needs well under a thousand cycles
   initial begin
      #200000;
      bad_count++;
      final_report();
   end

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH time=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check

   // Waits a bounded time for the next fetch pulse
   task automatic wait_fetch(input int n);
      int k;
      k = 0;
      while (fetch_seen == n && k < 40) begin
         @(negedge ref_clk);
         k++;
      end
      check(16'(fetch_seen != n), 16'h0001);
   endtask : wait_fetch

   // Holds the request until the vector is issued; the source then drops it
   task automatic fetch(input logic [24:0] req, input logic [4:0] ev, input logic [15:0] ea);
      int n;
      n = fetch_seen;
      @(negedge ref_clk);
      irq_request = req;
      wait_fetch(n);
      irq_request = '0;
      check(16'(fetch_vector), 16'(ev));
      check(fetch_address, ea);
      check(16'(fetch_is_reset), 16'h0000);
   endtask : fetch

   // One control write, held for exactly one taking edge
   task automatic ctrl(input logic unlock, input logic sel);
      @(negedge ref_clk);
      ctrl_write = 1'b1;
      ctrl_write_unlock = unlock;
      ctrl_write_select = sel;
      @(negedge ref_clk);
      ctrl_write = 1'b0;
   endtask : ctrl

   // Reset for 12 cycles with the fuse held steady, then the reset fetch
   task automatic do_reset(input logic fuse, input logic [15:0] ea);
      int n;
      @(negedge ref_clk);
      reset_n = 1'b0;
      boot_reset_select_fuse = fuse;
      repeat (12) @(negedge ref_clk);
      check(fetch_address, 16'h0000);
      check(16'(vector_table_select), 16'h0000);
      n = fetch_seen;
      reset_n = 1'b1;
      wait_fetch(n);
      check(16'(fetch_is_reset), 16'h0001);
      check(16'(fetch_vector), 16'h0001);
      check(fetch_address, ea);
   endtask : do_reset

   task automatic final_report;
      if (bad_count == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : final_report

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      int n;
      for (int i = 0; i < 25; i++) rows[i] = '{25'h1 << i, 5'(i + 2), 16'(2 * i + 2)};
      rows[25] = '{25'h0100020, 5'h07, 16'h000C};
      rows[26] = '{25'h1800000, 5'h19, 16'h0030};
      do_reset(1'b1, 16'h0000);
      // Prompt and slow service alternate so grants wait on the core
      for (int i = 0; i < 27; i++) begin
         service_cycles = i[0] ? 4'h6 : 4'h0;
         fetch(rows[i].req, rows[i].vec, rows[i].addr);
      end
      // Enable low holds a request back; then an unlock alone blocks four cycles
      global_irq_enable = 1'b0;
      irq_request = 25'h0000010;
      n = fetch_seen;
      repeat (6) @(negedge ref_clk);
      ctrl(1'b1, 1'b0);
      global_irq_enable = 1'b1;
      check(16'(irq_blocked), 16'h0001);
      for (int k = 0; k < 5; k++) begin
         check(16'(vector_change_unlock), 16'(k < 4));
         @(negedge ref_clk);
      end
      check(16'(fetch_seen - n), 16'h0000);
      fetch(25'h0000010, 5'h06, 16'h000A);
      // Move the table to the boot area with a request pending throughout
      ctrl(1'b1, 1'b0);
      irq_request = 25'h0000001;
      n = fetch_seen;
      ctrl(1'b0, 1'b1);
      check(16'(vector_table_select), 16'h0001);
      check(16'(vector_change_unlock), 16'h0000);
      check(16'(irq_blocked), 16'h0001);
      repeat (4) @(negedge ref_clk);
      check(16'(fetch_seen - n), 16'h0000);
      instr_done = 1'b1;
      @(negedge ref_clk);
      instr_done = 1'b0;
      check(16'(irq_blocked), 16'h0000);
      fetch(25'h0000001, 5'h02, BOOT_ADDR + 16'h0002);
      // A select write without unlock must be dropped
      ctrl(1'b0, 1'b0);
      check(16'(vector_table_select), 16'h0001);
      fetch(25'h1000000, 5'h1A, BOOT_ADDR + 16'h0032);
      // Mid-run reset with the fuse programmed
      do_reset(1'b0, BOOT_ADDR);
      fetch(25'h0000020, 5'h07, 16'h000C);
      final_report();
   end
endmodule : test_vector_address_map
